// *** tb_wdt_timer.sv ***
// Self-checking bench for the watchdog interval timer.
`timescale 1ns/1ns
module tb_wdt_timer;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic standby_i = 1'b0;
  logic [15:0] addr, wdata;
  logic wr, rd, irq, nmi, crst, pin_n, src;
  logic [7:0] rdata, v, d;
  int failures = 0;
  int tests_run = 0;
  int seed = 15;
  int n;
  always #5 ref_clk_i = ~ref_clk_i;
  wdt_cpu_model u_cpu (.ref_clk_i, .rdata_i(rdata), .addr_o(addr),
    .wr_word_o(wr), .wdata_o(wdata), .rd_o(rd));
  wdt_timer u_dut (.ref_clk_i, .arst_n_i, .clk_en_i, .standby_i,
    .addr_i(addr), .wr_word_i(wr), .wdata_i(wdata), .rd_i(rd),
    .rdata_o(rdata), .timer_overflow_interrupt_o(irq), .wdt_nmi_o(nmi),
    .chip_reset_o(crst), .reset_out_pin_n_o(pin_n),
    .reset_source_bit_o(src));
  function automatic int dv(input int c);
    int t[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
    return t[c];
  endfunction : dv
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic rx(input logic [15:0] a, input logic [7:0] e);
    u_cpu.rd(a, v);
    chk(v, e);
  endtask : rx
  task automatic wt(input int k);
    n = 0;
    while ((k == 0 ? irq : k == 1 ? nmi : crst) !== 1'b1 && n < 9000) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk({7'h00, n >= 9000}, 8'h00);
  endtask : wt
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  initial begin
    #600000;
    failures++;
    summarize();
  end
  initial begin
    #26 arst_n_i = 1'b1;
    rx(16'hFFA8, 8'h10);
    rx(16'hFFAA, 8'h00);
    chk({7'h00, src}, 8'h01);
    d = 8'($random(seed));
    v = (d == 8'h5A || d == 8'hA5) ? 8'h33 : d;
    u_cpu.wr(v, 8'h2F);
    rx(16'hFFA8, 8'h10);
    u_cpu.wr(8'hA5, 8'hA0);
    rx(16'hFFA8, 8'h30);
    wt(0);
    @(posedge ref_clk_i);
    #1;
    wt(0);
    chk(8'(n - 511), 8'h00);
    u_cpu.wr(8'hA5, 8'h20);
    rx(16'hFFA8, 8'hB0);
    u_cpu.wr(8'hA5, 8'h20);
    rx(16'hFFA8, 8'h30);
    u_cpu.wr(8'hA5, 8'h07);
    rx(16'hFFA9, 8'h00);
    u_cpu.wr(8'hA5, 8'h27);
    u_cpu.wr(8'h5A, d);
    rx(16'hFFA9, d);
    @(posedge ref_clk_i);
    #1 standby_i = 1'b1;
    @(posedge ref_clk_i);
    #1 standby_i = 1'b0;
    rx(16'hFFA8, 8'h17);
    // While frozen the read is not taken, so the last read byte stays.
    @(posedge ref_clk_i);
    #1 clk_en_i = 1'b0;
    rx(16'hFFA9, 8'h17);
    @(posedge ref_clk_i);
    #1 clk_en_i = 1'b1;
    rx(16'hFFA9, 8'h00);
    $display("register tests done");
    for (int c = 0; c < 8; c++) begin
      u_cpu.wr(8'hA5, 8'h00);
      u_cpu.wr(8'hA5, 8'h20 | 8'(c));
      u_cpu.wr(8'h5A, 8'hFF);
      wt(0);
      chk({7'h00, n + 6 > dv(c) && n < dv(c) + 6}, 8'h01);
    end
    $display("divider tests done");
    u_cpu.wr(8'hA5, 8'h00);
    u_cpu.wr(8'hA5, 8'h60);
    u_cpu.wr(8'h5A, 8'hFF);
    wt(1);
    chk({6'h00, crst, pin_n}, 8'h01);
    u_cpu.wr(8'hA5, 8'h00);
    u_cpu.wr(8'hA5, 8'h69);
    u_cpu.wr(8'h5A, 8'hFF);
    wt(2);
    chk({6'h00, pin_n, src}, 8'h00);
    n = 0;
    while (crst === 1'b1 && n < 600) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk(8'(n - 518), 8'h00);
    #3 arst_n_i = 1'b0;
    #20 arst_n_i = 1'b1;
    chk({7'h00, src}, 8'h01);
    rx(16'hFFA8, 8'h10);
    $display("watchdog tests done");
    summarize();
  end
endmodule : tb_wdt_timer

// *** wdt_checker.sv ***
// Port-level assertions for the watchdog interval timer.
`timescale 1ns/1ns
module wdt_checker (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic standby_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_word_i,
  input wire logic [15:0] wdata_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic timer_overflow_interrupt_o,
  input wire logic wdt_nmi_o,
  input wire logic chip_reset_o,
  input wire logic reset_out_pin_n_o,
  input wire logic reset_source_bit_o
);
  logic [9:0] hold_r;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // A counter, because 518 cycles is far past what a repetition may unroll.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_r <= 10'h000;
    end else begin
      hold_r <= chip_reset_o ? hold_r + 10'h001 : 10'h000;
    end
  end
  a_pin_follows: assert property (reset_out_pin_n_o != chip_reset_o)
    else $error("reset-out pin wrong");
  a_hold_length: assert property (
    $fell(chip_reset_o) |-> hold_r == 10'd518) else $error("hold length");
  a_source_cleared: assert property (
    $rose(chip_reset_o) |-> !reset_source_bit_o) else $error("source set");
  a_source_falls: assert property (
    $fell(reset_source_bit_o) |-> $rose(chip_reset_o)) else $error("source");
  a_reset_no_irq: assert property ($rose(chip_reset_o) |->
    !wdt_nmi_o && !timer_overflow_interrupt_o) else $error("irq on reset");
  a_single_request: assert property (
    !(wdt_nmi_o && timer_overflow_interrupt_o)) else $error("two requests");
  a_irq_pulse: assert property (timer_overflow_interrupt_o |=>
    !timer_overflow_interrupt_o) else $error("irq too long");
  a_reserved_one: assert property (
    rd_i && clk_en_i && addr_i == 16'hFFA8 |=> rdata_o[4]) else $error("bit4");
  a_read_holds: assert property (!(rd_i && clk_en_i) |=>
    $stable(rdata_o)) else $error("read data moved");
  c_irq: cover property (timer_overflow_interrupt_o);
  c_nmi: cover property (wdt_nmi_o);
  c_chip_reset: cover property ($fell(chip_reset_o));
endmodule : wdt_checker
bind wdt_timer wdt_checker u_chk (.ref_clk_i, .arst_n_i, .clk_en_i,
  .standby_i, .addr_i, .wr_word_i, .wdata_i, .rd_i, .rdata_o,
  .timer_overflow_interrupt_o, .wdt_nmi_o, .chip_reset_o,
  .reset_out_pin_n_o, .reset_source_bit_o);

// *** wdt_cpu_model.sv ***
// Bus master standing in for the processor.
`timescale 1ns/1ns
module wdt_cpu_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  output logic [15:0] addr_o,
  output logic wr_word_o,
  output logic [15:0] wdata_o,
  output logic rd_o
);
  initial begin
    addr_o = 16'h0000;
    wr_word_o = 1'b0;
    wdata_o = 16'h0000;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] pw, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    addr_o = 16'hFFA8;
    wdata_o = {pw, d};
    wr_word_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    wr_word_o = 1'b0;
    // Released data is inverted, so a stale value differs from the last word written.
    wdata_o = ~wdata_o;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    rd_o = 1'b0;
    v = rdata_i;
  endtask : rd
endmodule : wdt_cpu_model

// *** wdt_pkg.sv ***
// Types shared by the watchdog interval timer.
package wdt_pkg;
  typedef enum logic [1:0] {
    WDT_RST_IDLE = 2'b00,
    WDT_RST_HOLD = 2'b01
  } wdt_rst_state_t;
endpackage : wdt_pkg

// *** wdt_prescaler.sv ***
// Prescaler, cleared while the timer is off, and divide-ratio tick selection.
`timescale 1ns/1ns
`include "wdt_regs.svh"
module wdt_prescaler (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic run_i,
  input wire logic [`WDT_CKS_W-1:0] cks_i,
  output logic tick_o
);
  logic [`WDT_PRESC_W-1:0] presc_r;
  logic [`WDT_PRESC_W-1:0] presc_nxt;
  logic [7:0] taps;

  // Prescaler stays cleared while the timer is off so intervals start clean.
  assign presc_nxt = presc_r + {{(`WDT_PRESC_W-1){1'b0}}, 1'b1};

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      presc_r <= '0;
    end else if (clk_en_i) begin
      if (!run_i) begin
        presc_r <= '0;
      end else begin
        presc_r <= presc_nxt;
      end
    end
  end

  // A tick fires when the lower bits roll over: divide by 2, 32, 64, 128, 256, 512, 2048 or 4096.
  always_comb begin
    taps[0] = &presc_r[0:0];
    taps[1] = &presc_r[4:0];
    taps[2] = &presc_r[5:0];
    taps[3] = &presc_r[6:0];
    taps[4] = &presc_r[7:0];
    taps[5] = &presc_r[8:0];
    taps[6] = &presc_r[10:0];
    taps[7] = &presc_r[11:0];
  end

  assign tick_o = run_i & clk_en_i & taps[cks_i];
endmodule : wdt_prescaler

// *** wdt_regs.svh ***
// Register map, field positions, passwords and timing constants.
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH
`define WDT_ADDR_WRITE 16'hFFA8
`define WDT_ADDR_RD_CSR 16'hFFA8
`define WDT_ADDR_RD_CNT 16'hFFA9
`define WDT_PASS_CNT 8'h5A
`define WDT_PASS_CSR 8'hA5
`define WDT_CSR_RESET 8'h10
`define WDT_CSR_RSV_MASK 8'h10
`define WDT_CSR_WR_MASK 8'h6F
`define WDT_BIT_OVF 7
`define WDT_BIT_MODE 6
`define WDT_BIT_TME 5
`define WDT_BIT_RSTSEL 3
`define WDT_CNT_MAX 8'hFF
`define WDT_CNT_ZERO 8'h00
`define WDT_BYTE_ZERO 8'h00
`define WDT_RST_HOLD_CYC 10'd518
`define WDT_PRESC_W 12
`define WDT_CKS_W 3
`endif

// *** wdt_timer.sv ***
// Watchdog / interval timer with password-protected word writes.
`timescale 1ns/1ns
`include "wdt_regs.svh"
module wdt_timer
  import wdt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic standby_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_word_i,
  input wire logic [15:0] wdata_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic timer_overflow_interrupt_o,
  output logic wdt_nmi_o,
  output logic chip_reset_o,
  output logic reset_out_pin_n_o,
  output logic reset_source_bit_o
);
  logic [7:0] wdt_count_r;
  logic overflow_flag_r;
  logic mode_select_bit_r;
  logic timer_enable_bit_r;
  logic rst_select_r;
  logic [2:0] clock_select_r;
  logic ovf_seen_r;
  logic reset_source_bit_r;
  logic [7:0] rdata_r;
  logic [9:0] hold_cnt_r;
  wdt_rst_state_t rst_state_r;
  logic tick;
  logic overflow;
  logic wr_addr_hit;
  logic wr_cnt;
  logic wr_csr;
  logic [7:0] csr_view;

  assign wr_addr_hit = wr_word_i && (addr_i == `WDT_ADDR_WRITE);
  assign wr_cnt = wr_addr_hit && (wdata_i[15:8] == `WDT_PASS_CNT);
  assign wr_csr = wr_addr_hit && (wdata_i[15:8] == `WDT_PASS_CSR);
  // Any other high byte matches neither decode, so nothing changes.

  wdt_prescaler u_presc (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .clk_en_i(clk_en_i),
    .run_i(timer_enable_bit_r),
    .cks_i(clock_select_r),
    .tick_o(tick)
  );

  // Overflow is a real wrap only; a counter write in the same cycle cancels it.
  assign overflow = tick && !wr_cnt && (wdt_count_r == `WDT_CNT_MAX);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdt_count_r <= `WDT_CNT_ZERO;
    end else if (clk_en_i) begin
      if (standby_i || !timer_enable_bit_r) begin
        wdt_count_r <= `WDT_CNT_ZERO;
      end else if (wr_cnt) begin
        wdt_count_r <= wdata_i[7:0];
      end else if (tick) begin
        wdt_count_r <= wdt_count_r + 8'h01;
      end
    end
  end

  // Control bits; standby clears all but the clock select field.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_select_bit_r <= 1'b0;
      timer_enable_bit_r <= 1'b0;
      rst_select_r <= 1'b0;
      clock_select_r <= 3'h0;
    end else if (clk_en_i) begin
      if (standby_i) begin
        mode_select_bit_r <= 1'b0;
        timer_enable_bit_r <= 1'b0;
        rst_select_r <= 1'b0;
      end else if (wr_csr) begin
        mode_select_bit_r <= wdata_i[`WDT_BIT_MODE];
        timer_enable_bit_r <= wdata_i[`WDT_BIT_TME];
        rst_select_r <= wdata_i[`WDT_BIT_RSTSEL];
        clock_select_r <= wdata_i[`WDT_CKS_W-1:0];
      end
    end
  end

  // Outside standby the flag clears only after being read set; a new overflow wins.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      overflow_flag_r <= 1'b0;
      ovf_seen_r <= 1'b0;
    end else if (clk_en_i) begin
      if (standby_i) begin
        overflow_flag_r <= 1'b0;
        ovf_seen_r <= 1'b0;
      end else if (overflow) begin
        overflow_flag_r <= 1'b1;
        ovf_seen_r <= 1'b0;
      end else if (wr_csr && !wdata_i[`WDT_BIT_OVF] && ovf_seen_r) begin
        overflow_flag_r <= 1'b0;
        ovf_seen_r <= 1'b0;
      end else if (rd_i && addr_i == `WDT_ADDR_RD_CSR && overflow_flag_r) begin
        ovf_seen_r <= 1'b1;
      end
    end
  end

  assign csr_view = {overflow_flag_r, mode_select_bit_r, timer_enable_bit_r,
                     1'b1, rst_select_r, clock_select_r};

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= `WDT_BYTE_ZERO;
    end else if (clk_en_i && rd_i) begin
      if (addr_i == `WDT_ADDR_RD_CSR) begin
        rdata_r <= csr_view;
      end else if (addr_i == `WDT_ADDR_RD_CNT) begin
        rdata_r <= wdt_count_r;
      end else begin
        rdata_r <= `WDT_BYTE_ZERO;
      end
    end
  end
  assign rdata_o = rdata_r;

  // Overflow events to the CPU; one-cycle pulses from flip-flops.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_overflow_interrupt_o <= 1'b0;
      wdt_nmi_o <= 1'b0;
    end else if (clk_en_i) begin
      timer_overflow_interrupt_o <= overflow && !mode_select_bit_r;
      wdt_nmi_o <= overflow && mode_select_bit_r && !rst_select_r;
    end
  end

  // Internal chip reset is held a fixed count; reset-out follows it.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_state_r <= WDT_RST_IDLE;
      hold_cnt_r <= 10'h000;
    end else if (clk_en_i) begin
      case (rst_state_r)
        WDT_RST_IDLE: begin
          if (overflow && mode_select_bit_r && rst_select_r) begin
            rst_state_r <= WDT_RST_HOLD;
            hold_cnt_r <= `WDT_RST_HOLD_CYC - 10'd1;
          end
        end
        WDT_RST_HOLD: begin
          if (hold_cnt_r == 10'h000) begin
            rst_state_r <= WDT_RST_IDLE;
          end else begin
            hold_cnt_r <= hold_cnt_r - 10'd1;
          end
        end
        default: begin
          rst_state_r <= WDT_RST_IDLE;
        end
      endcase
    end
  end
  assign chip_reset_o = (rst_state_r == WDT_RST_HOLD);
  assign reset_out_pin_n_o = !(rst_state_r == WDT_RST_HOLD);

  // Only the external reset pin sets the source bit back to one.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reset_source_bit_r <= 1'b1;
    end else if (clk_en_i && overflow && mode_select_bit_r && rst_select_r) begin
      reset_source_bit_r <= 1'b0;
    end
  end
  assign reset_source_bit_o = reset_source_bit_r;
endmodule : wdt_timer
